// ### core/gma_gpio_core.sv
// Pin multiplexer, pin change detector and interrupt aggregator for 40 open-drain pins.
// Assumes pin inputs and all configuration ports are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module gma_gpio_core
	import gma_pkg::*;
#(
	parameter int CHAN_IN_FUNCS = gma_pkg::DEF_CHAN_IN_FUNCS,
	parameter int CHAN_OUT_FUNCS = gma_pkg::DEF_CHAN_OUT_FUNCS,
	parameter int GLOBAL_IN_FUNCS = gma_pkg::DEF_GLOBAL_IN_FUNCS,
	parameter int CHIP_OUT_FUNCS = gma_pkg::DEF_CHIP_OUT_FUNCS,
	parameter int CHAN_IRQ_SRCS = gma_pkg::DEF_CHAN_IRQ_SRCS,
	parameter int CHIP_IRQ_SRCS = gma_pkg::DEF_CHIP_IRQ_SRCS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [gma_pkg::PIN_COUNT-1:0] pinIn,
	output logic [gma_pkg::PIN_COUNT-1:0] pinOut,
	output logic [gma_pkg::PIN_COUNT-1:0] pinOe,
	input wire logic chanInSelLoad,
	input wire logic [gma_pkg::CHAN_COUNT*CHAN_IN_FUNCS*gma_pkg::SEL_W-1:0] chanInSelValue,
	input wire logic globalInSelLoad,
	input wire logic [GLOBAL_IN_FUNCS*gma_pkg::SEL_W-1:0] globalInSelValue,
	input wire logic vOutSelLoad,
	input wire logic [gma_pkg::VOUT_TOTAL*gma_pkg::VSEL_W-1:0] vOutSelValue,
	input wire logic pinOutSelLoad,
	input wire logic [gma_pkg::PIN_COUNT*gma_pkg::SEL_W-1:0] pinOutSelValue,
	output logic [gma_pkg::CHAN_COUNT*CHAN_IN_FUNCS-1:0] chanInFunc,
	output logic [GLOBAL_IN_FUNCS-1:0] globalInFunc,
	input wire logic [gma_pkg::CHAN_COUNT*CHAN_OUT_FUNCS-1:0] chanOutFunc,
	input wire logic [CHIP_OUT_FUNCS-1:0] chipOutFunc,
	output logic [gma_pkg::PIN_COUNT-1:0] pinLevel,
	output logic [gma_pkg::PIN_COUNT-1:0] pinChangeSticky,
	input wire logic [gma_pkg::PIN_COUNT-1:0] pinChangeClear,
	input wire logic [gma_pkg::PIN_COUNT-1:0] pinChangeIrqEn,
	output logic [gma_pkg::PIN_COUNT-1:0] pinChangeMasked,
	input wire logic [gma_pkg::CHAN_COUNT*CHAN_IRQ_SRCS-1:0] chanIrqSrc,
	input wire logic [gma_pkg::CHAN_GEN_TOTAL*CHAN_IRQ_SRCS-1:0] chanIrqEn,
	output logic [gma_pkg::CHAN_GEN_TOTAL*CHAN_IRQ_SRCS-1:0] chanIrqMasked,
	output logic [gma_pkg::CHAN_GEN_TOTAL-1:0] chanIrq,
	input wire logic [CHIP_IRQ_SRCS-1:0] chipIrqSrc,
	input wire logic [gma_pkg::AGG_COUNT*(CHIP_IRQ_SRCS+gma_pkg::CHAN_GEN_TOTAL)-1:0] aggIrqEn,
	output logic [gma_pkg::AGG_COUNT*(CHIP_IRQ_SRCS+gma_pkg::CHAN_GEN_TOTAL)-1:0] aggIrqMasked,
	output logic [gma_pkg::AGG_COUNT-1:0] aggIrqN
);
	import gma_pkg::*;

	localparam int CIN_TOTAL = CHAN_COUNT * CHAN_IN_FUNCS;
	localparam int AGG_SRCS = CHIP_IRQ_SRCS + CHAN_GEN_TOTAL;
	localparam int IN_CHOICES = PIN_COUNT + 2;
	localparam int OUT_CHOICES = OUT_SEL_CHIP_BASE + CHIP_OUT_FUNCS;

	// Configuration registers; each group is replaced whole on its load strobe.
	logic [SEL_W-1:0] chanInSel_reg [CIN_TOTAL];
	logic [SEL_W-1:0] chanInSel_next [CIN_TOTAL];
	logic [SEL_W-1:0] globalInSel_reg [GLOBAL_IN_FUNCS];
	logic [SEL_W-1:0] globalInSel_next [GLOBAL_IN_FUNCS];
	logic [VSEL_W-1:0] vOutSel_reg [VOUT_TOTAL];
	logic [VSEL_W-1:0] vOutSel_next [VOUT_TOTAL];
	logic [SEL_W-1:0] pinOutSel_reg [PIN_COUNT];
	logic [SEL_W-1:0] pinOutSel_next [PIN_COUNT];

	// Datapath registers.
	logic [PIN_COUNT-1:0] pinPrev_reg, pinPrev_next;
	logic primed_reg, primed_next;
	logic [PIN_COUNT-1:0] sticky_reg, sticky_next;
	logic [PIN_COUNT-1:0] pinOe_reg, pinOe_next;
	logic [CIN_TOTAL-1:0] chanInFunc_reg, chanInFunc_next;
	logic [GLOBAL_IN_FUNCS-1:0] globalInFunc_reg, globalInFunc_next;
	logic [CHAN_GEN_TOTAL*CHAN_IRQ_SRCS-1:0] chanMasked_reg, chanMasked_next;
	logic [CHAN_GEN_TOTAL-1:0] chanIrq_reg, chanIrq_next;
	logic [AGG_COUNT*AGG_SRCS-1:0] aggMasked_reg, aggMasked_next;
	logic [PIN_COUNT-1:0] pinChgMasked_reg, pinChgMasked_next;
	logic [AGG_COUNT-1:0] aggIrqN_reg, aggIrqN_next;

	// Mux outputs.
	logic [CIN_TOTAL-1:0] chanInPick;
	logic [GLOBAL_IN_FUNCS-1:0] globalInPick;
	logic [VOUT_TOTAL-1:0] vOutPick;
	logic [PIN_COUNT-1:0] pinOutPick;
	logic [IN_CHOICES-1:0] inChoices;
	logic [OUT_CHOICES-1:0] outChoices;
	logic [AGG_SRCS-1:0] aggSources;

	// Default code of a global input selector after reset.
	function automatic logic [SEL_W-1:0] globalInDefault(input int idx);
		if (idx == TWS_DATA_IN_FUNC) begin
			return TWS_DATA_PIN;
		end else if (idx == TWS_CLK_IN_FUNC) begin
			return TWS_CLK_PIN;
		end
		return IN_SEL_CONST0;
	endfunction

	// Default code of a pin output selector after reset.
	function automatic logic [SEL_W-1:0] pinOutDefault(input int idx);
		if (idx == TWS_DATA_OUT_PIN) begin
			return TWS_DATA_OUT_SEL;
		end
		return OUT_SEL_OFF;
	endfunction

	// The two constants sit above the pins so that a pin code equals its index.
	assign inChoices = {1'b1, 1'b0, pinIn};

	// A disabled pin and a static high both release the line.
	assign outChoices = {chipOutFunc, aggIrqN_reg, vOutPick,
		PIN_RELEASED, 1'b0, PIN_RELEASED};

	assign aggSources = {chanIrq_reg, chipIrqSrc};

	genvar g;
	generate
		for (g = 0; g < CIN_TOTAL; g++) begin : genChanIn
			gma_bit_select #(.WIDTH(IN_CHOICES), .SEL_BITS(SEL_W)) chanInMux (
				.choices(inChoices),
				.sel(chanInSel_reg[g]),
				.picked(chanInPick[g])
			);
		end
		for (g = 0; g < GLOBAL_IN_FUNCS; g++) begin : genGlobalIn
			gma_bit_select #(.WIDTH(IN_CHOICES), .SEL_BITS(SEL_W)) globalInMux (
				.choices(inChoices),
				.sel(globalInSel_reg[g]),
				.picked(globalInPick[g])
			);
		end
		// A channel has exactly eight virtual outputs, which caps its output functions in use.
		for (g = 0; g < VOUT_TOTAL; g++) begin : genVOut
			gma_bit_select #(.WIDTH(CHAN_OUT_FUNCS), .SEL_BITS(VSEL_W)) vOutMux (
				.choices(chanOutFunc[(g/VOUT_PER_CHAN)*CHAN_OUT_FUNCS +: CHAN_OUT_FUNCS]),
				.sel(vOutSel_reg[g]),
				.picked(vOutPick[g])
			);
		end
		for (g = 0; g < PIN_COUNT; g++) begin : genPinOut
			gma_bit_select #(.WIDTH(OUT_CHOICES), .SEL_BITS(SEL_W)) pinOutMux (
				.choices(outChoices),
				.sel(pinOutSel_reg[g]),
				.picked(pinOutPick[g])
			);
		end
	endgenerate

	// Configuration next state.
	always_comb begin
		for (int i = 0; i < CIN_TOTAL; i++) begin
			chanInSel_next[i] = chanInSel_reg[i];
			if (chanInSelLoad) begin
				chanInSel_next[i] = chanInSelValue[i*SEL_W +: SEL_W];
			end
		end
		for (int i = 0; i < GLOBAL_IN_FUNCS; i++) begin
			globalInSel_next[i] = globalInSel_reg[i];
			if (globalInSelLoad) begin
				globalInSel_next[i] = globalInSelValue[i*SEL_W +: SEL_W];
			end
		end
		for (int i = 0; i < VOUT_TOTAL; i++) begin
			vOutSel_next[i] = vOutSel_reg[i];
			if (vOutSelLoad) begin
				vOutSel_next[i] = vOutSelValue[i*VSEL_W +: VSEL_W];
			end
		end
		for (int i = 0; i < PIN_COUNT; i++) begin
			pinOutSel_next[i] = pinOutSel_reg[i];
			if (pinOutSelLoad) begin
				pinOutSel_next[i] = pinOutSelValue[i*SEL_W +: SEL_W];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < CIN_TOTAL; i++) begin
				chanInSel_reg[i] <= IN_SEL_CONST0;
			end
			for (int i = 0; i < GLOBAL_IN_FUNCS; i++) begin
				globalInSel_reg[i] <= globalInDefault(i);
			end
			for (int i = 0; i < VOUT_TOTAL; i++) begin
				vOutSel_reg[i] <= VOUT_SEL_RESET;
			end
			for (int i = 0; i < PIN_COUNT; i++) begin
				pinOutSel_reg[i] <= pinOutDefault(i);
			end
		end else begin
			chanInSel_reg <= chanInSel_next;
			globalInSel_reg <= globalInSel_next;
			vOutSel_reg <= vOutSel_next;
			pinOutSel_reg <= pinOutSel_next;
		end
	end

	// Datapath next state.
	always_comb begin
		pinPrev_next = pinIn;
		primed_next = 1'b1;
		// The first cycle after reset has no valid previous level, so it cannot flag a change.
		sticky_next = (sticky_reg & ~pinChangeClear)
			| ((pinIn ^ pinPrev_reg) & {PIN_COUNT{primed_reg}});
		// Open drain: enable the driver only when the selected level is low.
		pinOe_next = ~pinOutPick;
		chanInFunc_next = chanInPick;
		globalInFunc_next = globalInPick;
		for (int gen = 0; gen < CHAN_GEN_TOTAL; gen++) begin
			chanMasked_next[gen*CHAN_IRQ_SRCS +: CHAN_IRQ_SRCS] =
				chanIrqSrc[(gen/CHAN_IRQ_GENS)*CHAN_IRQ_SRCS +: CHAN_IRQ_SRCS]
				& chanIrqEn[gen*CHAN_IRQ_SRCS +: CHAN_IRQ_SRCS];
			chanIrq_next[gen] = |chanMasked_next[gen*CHAN_IRQ_SRCS +: CHAN_IRQ_SRCS];
		end
		pinChgMasked_next = sticky_reg & pinChangeIrqEn;
		for (int a = 0; a < AGG_COUNT; a++) begin
			aggMasked_next[a*AGG_SRCS +: AGG_SRCS] =
				aggSources & aggIrqEn[a*AGG_SRCS +: AGG_SRCS];
			// Active low so several devices can share one pulled-up line.
			aggIrqN_next[a] = ~(|aggMasked_next[a*AGG_SRCS +: AGG_SRCS]
				| |pinChgMasked_next);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pinPrev_reg <= '0;
			primed_reg <= 1'b0;
			sticky_reg <= '0;
			pinOe_reg <= '0;
			chanInFunc_reg <= '0;
			globalInFunc_reg <= '0;
			chanMasked_reg <= '0;
			chanIrq_reg <= '0;
			aggMasked_reg <= '0;
			pinChgMasked_reg <= '0;
			aggIrqN_reg <= '1;
		end else begin
			pinPrev_reg <= pinPrev_next;
			primed_reg <= primed_next;
			sticky_reg <= sticky_next;
			pinOe_reg <= pinOe_next;
			chanInFunc_reg <= chanInFunc_next;
			globalInFunc_reg <= globalInFunc_next;
			chanMasked_reg <= chanMasked_next;
			chanIrq_reg <= chanIrq_next;
			aggMasked_reg <= aggMasked_next;
			pinChgMasked_reg <= pinChgMasked_next;
			aggIrqN_reg <= aggIrqN_next;
		end
	end

	// Pins never drive high; the driven value is always low.
	assign pinOut = '0;
	assign pinOe = pinOe_reg;
	assign pinLevel = pinPrev_reg;
	assign pinChangeSticky = sticky_reg;
	assign pinChangeMasked = pinChgMasked_reg;
	assign chanInFunc = chanInFunc_reg;
	assign globalInFunc = globalInFunc_reg;
	assign chanIrqMasked = chanMasked_reg;
	assign chanIrq = chanIrq_reg;
	assign aggIrqMasked = aggMasked_reg;
	assign aggIrqN = aggIrqN_reg;

endmodule // gma_gpio_core
`default_nettype wire

// ### core/gma_pkg.sv
// Shared constants for the pin multiplexer and interrupt aggregator.
// Assumes one clock domain; IN_SEL_CONST1, OUT_SEL_LOW and OUT_SEL_HIGH are not named by the core or the bench.
package gma_pkg;

	// Fixed structure of the block.
	localparam int PIN_COUNT = 40;
	localparam int CHAN_COUNT = 4;
	localparam int VOUT_PER_CHAN = 8;
	localparam int CHAN_IRQ_GENS = 2;
	localparam int AGG_COUNT = 4;
	localparam int CHAN_GEN_TOTAL = CHAN_COUNT * CHAN_IRQ_GENS;
	localparam int VOUT_TOTAL = CHAN_COUNT * VOUT_PER_CHAN;

	// Defaults for counts that a derivative could change.
	localparam int DEF_CHAN_IN_FUNCS = 8;
	localparam int DEF_CHAN_OUT_FUNCS = 16;
	localparam int DEF_GLOBAL_IN_FUNCS = 4;
	localparam int DEF_CHIP_OUT_FUNCS = 4;
	localparam int DEF_CHAN_IRQ_SRCS = 8;
	localparam int DEF_CHIP_IRQ_SRCS = 4;

	// Input selector codes: 0 to 39 pick a pin, then two forced constants.
	localparam int SEL_W = 6;
	localparam logic [SEL_W-1:0] IN_SEL_CONST0 = 6'h28;
	localparam logic [SEL_W-1:0] IN_SEL_CONST1 = 6'h29;
	localparam logic [SEL_W-1:0] TWS_DATA_PIN = 6'h20;
	localparam logic [SEL_W-1:0] TWS_CLK_PIN = 6'h21;
	localparam int TWS_DATA_IN_FUNC = 0;
	localparam int TWS_CLK_IN_FUNC = 1;

	// Pin output selector codes.
	localparam logic [SEL_W-1:0] OUT_SEL_OFF = 6'h00;
	localparam logic [SEL_W-1:0] OUT_SEL_LOW = 6'h01;
	localparam logic [SEL_W-1:0] OUT_SEL_HIGH = 6'h02;
	localparam int OUT_SEL_VOUT_BASE = 3;
	localparam int OUT_SEL_AGG_BASE = OUT_SEL_VOUT_BASE + VOUT_TOTAL;
	localparam int OUT_SEL_CHIP_BASE = OUT_SEL_AGG_BASE + AGG_COUNT;
	localparam int TWS_DATA_OUT_FUNC = 0;
	localparam logic [SEL_W-1:0] TWS_DATA_OUT_SEL = 6'h27;
	localparam int TWS_DATA_OUT_PIN = 32;

	// Virtual output selector width and reset code.
	localparam int VSEL_W = 4;
	localparam logic [VSEL_W-1:0] VOUT_SEL_RESET = 4'h0;

	// Level that an open-drain pin shows when released.
	localparam logic PIN_RELEASED = 1'b1;

endpackage

// ### core/gma_bit_select.sv
// Generic one-of-N bit selector used for every multiplexer in the core.
// Assumes the selector is stable within the cycle; codes past the last choice give zero.
`timescale 1ns/1ps
`default_nettype none
module gma_bit_select #(
	parameter int WIDTH = 2,
	parameter int SEL_BITS = 1
) (
	input wire logic [WIDTH-1:0] choices,
	input wire logic [SEL_BITS-1:0] sel,
	output logic picked
);

	always_comb begin
		picked = 1'b0;
		if (int'(sel) < WIDTH) begin
			picked = choices[sel];
		end
	end

endmodule // gma_bit_select
`default_nettype wire

// ### dv/gma_gpio_props.sv
// Concurrent checks on the ports of the pin multiplexer and interrupt aggregator.
// Assumes one clock domain and a bind onto gma_gpio_core from the bench.
`timescale 1ns/1ps
`default_nettype none
module gma_gpio_props
	import gma_pkg::*;
#(
	parameter int CHAN_IRQ_SRCS = gma_pkg::DEF_CHAN_IRQ_SRCS,
	parameter int CHIP_IRQ_SRCS = gma_pkg::DEF_CHIP_IRQ_SRCS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [PIN_COUNT-1:0] pinOut,
	input wire logic [PIN_COUNT-1:0] pinLevel,
	input wire logic [PIN_COUNT-1:0] pinChangeSticky,
	input wire logic [PIN_COUNT-1:0] pinChangeClear,
	input wire logic [PIN_COUNT-1:0] pinChangeIrqEn,
	input wire logic [PIN_COUNT-1:0] pinChangeMasked,
	input wire logic [CHAN_COUNT*CHAN_IRQ_SRCS-1:0] chanIrqSrc,
	input wire logic [CHAN_GEN_TOTAL*CHAN_IRQ_SRCS-1:0] chanIrqEn,
	input wire logic [CHAN_GEN_TOTAL*CHAN_IRQ_SRCS-1:0] chanIrqMasked,
	input wire logic [CHAN_GEN_TOTAL-1:0] chanIrq,
	input wire logic [CHIP_IRQ_SRCS-1:0] chipIrqSrc,
	input wire logic [AGG_COUNT*(CHIP_IRQ_SRCS+CHAN_GEN_TOTAL)-1:0] aggIrqEn,
	input wire logic [AGG_COUNT*(CHIP_IRQ_SRCS+CHAN_GEN_TOTAL)-1:0] aggIrqMasked,
	input wire logic [AGG_COUNT-1:0] aggIrqN
);
	localparam int CS = CHAN_IRQ_SRCS;
	localparam int AS = CHIP_IRQ_SRCS + CHAN_GEN_TOTAL;
	logic [CHAN_GEN_TOTAL*CS-1:0] chanExp;
	logic [AGG_COUNT*AS-1:0] aggExp;
	logic [CHAN_GEN_TOTAL-1:0] chanOr;
	logic [AGG_COUNT-1:0] aggOr;
	// Masks are formed here so that $past only ever looks at a plain signal.
	always_comb begin
		for (int g = 0; g < CHAN_GEN_TOTAL; g++) begin
			chanExp[g*CS +: CS] = chanIrqSrc[(g/CHAN_IRQ_GENS)*CS +: CS] & chanIrqEn[g*CS +: CS];
			chanOr[g] = |chanIrqMasked[g*CS +: CS];
		end
		for (int a = 0; a < AGG_COUNT; a++) begin
			aggExp[a*AS +: AS] = {chanIrq, chipIrqSrc} & aggIrqEn[a*AS +: AS];
			aggOr[a] = |aggIrqMasked[a*AS +: AS];
		end
	end
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);
	property p_openDrain; pinOut == '0; endproperty
	property p_stickyHold;
		!$past(rst) |-> &(pinChangeSticky | ~$past(pinChangeSticky) | $past(pinChangeClear));
	endproperty
	// A cleared bit may only come back when the pin changed on the clearing edge, since set wins.
	property p_stickyClear;
		!$past(rst) |-> (pinChangeSticky & $past(pinChangeClear)
			& ~(pinLevel ^ $past(pinLevel))) == '0;
	endproperty
	property p_pinMask;
		!$past(rst) |-> pinChangeMasked == ($past(pinChangeSticky) & $past(pinChangeIrqEn));
	endproperty
	property p_chanMasked; !$past(rst) |-> chanIrqMasked == $past(chanExp); endproperty
	property p_chanIrq; chanIrq == chanOr; endproperty
	property p_aggMasked; !$past(rst) |-> aggIrqMasked == $past(aggExp); endproperty
	property p_aggOut; aggIrqN == ~(aggOr | {AGG_COUNT{|pinChangeMasked}}); endproperty
	a_openDrain: assert property (p_openDrain) else $error("pin driven high");
	a_stickyHold: assert property (p_stickyHold) else $error("change flag lost");
	a_stickyClear: assert property (p_stickyClear) else $error("change flag not cleared");
	a_pinMask: assert property (p_pinMask) else $error("pin change mask wrong");
	a_chanMasked: assert property (p_chanMasked) else $error("channel masked wrong");
	a_chanIrq: assert property (p_chanIrq) else $error("channel interrupt wrong");
	a_aggMasked: assert property (p_aggMasked) else $error("aggregate masked wrong");
	a_aggOut: assert property (p_aggOut) else $error("aggregate output wrong");
	c_sticky: cover property ($rose(|pinChangeSticky));
	c_aggLow: cover property ($fell(aggIrqN[0]));
	c_chanIrq: cover property (|chanIrq);
endmodule // gma_gpio_props
`default_nettype wire

// ### dv/gma_module_model.sv
// Far side of the pins: module status lines sharing open-drain wires with pull-ups.
// Assumes every pin has a pull-up, so a released wire reads high.
`timescale 1ns/1ps
`default_nettype none
module gma_module_model
	import gma_pkg::*;
(
	input wire logic [gma_pkg::PIN_COUNT-1:0] pinOe,
	input wire logic [gma_pkg::PIN_COUNT-1:0] modStatus,
	output logic [gma_pkg::PIN_COUNT-1:0] pinIn
);
	// Wired-AND: either side pulling low wins, which is why the core may never drive high.
	assign pinIn = modStatus & ~pinOe;
endmodule // gma_module_model
`default_nettype wire

// ### dv/gma_gpio_core_bench.sv
// Self-checking bench for the pin multiplexer and interrupt aggregator.
// Assumes the package, core, checker and module model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin checksDone++; if ((got) !== (exp)) begin miscompares++; \
	$display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module gma_gpio_core_bench;
	import gma_pkg::*;
	typedef struct {int kind; logic [63:0] val;} gma_expect_type;
	gma_expect_type expQ[$];
	gma_expect_type cur;
	int miscompares = 0, checksDone = 0, cycles = 0, v;
	logic clk = 1'b0, rst = 1'b1;
	logic chanInSelLoad, globalInSelLoad, vOutSelLoad, pinOutSelLoad;
	logic [39:0] pinIn, pinOut, pinOe, pinLevel, sticky, stickyClr, pinChgEn, pinChgMasked, modStatus, m, c;
	logic [191:0] chanInSel;
	logic [23:0] globalInSel;
	logic [127:0] vOutSel, vs;
	logic [239:0] pinOutSel;
	logic [31:0] chanInFunc, chanIrqSrc, cs;
	logic [3:0] globalInFunc, chipOutFunc, chipIrqSrc, aggIrqN, ch;
	logic [63:0] chanOutFunc, chanIrqEn, chanIrqMasked, e, ce;
	logic [7:0] chanIrq;
	logic [47:0] aggIrqEn, aggIrqMasked, ae;
	logic [5:0] code;
	always #12.5 clk = ~clk;
	gma_gpio_core u_gma_gpio_core (.clk(clk), .rst(rst), .pinIn(pinIn), .pinOut(pinOut),
		.pinOe(pinOe), .chanInSelLoad(chanInSelLoad), .chanInSelValue(chanInSel),
		.globalInSelLoad(globalInSelLoad), .globalInSelValue(globalInSel), .vOutSelLoad(vOutSelLoad),
		.vOutSelValue(vOutSel), .pinOutSelLoad(pinOutSelLoad), .pinOutSelValue(pinOutSel),
		.chanInFunc(chanInFunc), .globalInFunc(globalInFunc), .chanOutFunc(chanOutFunc),
		.chipOutFunc(chipOutFunc), .pinLevel(pinLevel), .pinChangeSticky(sticky),
		.pinChangeClear(stickyClr), .pinChangeIrqEn(pinChgEn), .pinChangeMasked(pinChgMasked),
		.chanIrqSrc(chanIrqSrc), .chanIrqEn(chanIrqEn), .chanIrqMasked(chanIrqMasked),
		.chanIrq(chanIrq), .chipIrqSrc(chipIrqSrc), .aggIrqEn(aggIrqEn),
		.aggIrqMasked(aggIrqMasked), .aggIrqN(aggIrqN));
	gma_module_model u_gma_module_model (.pinOe(pinOe), .modStatus(modStatus), .pinIn(pinIn));
	function automatic logic [63:0] observe(int kind);
		case (kind)
			0: return 64'(pinOe);
			1: return 64'(chanInFunc);
			2: return 64'(globalInFunc);
			3: return 64'(sticky);
			4: return 64'(aggIrqN);
			5: return 64'(chanIrq);
			default: return 64'(pinLevel);
		endcase
	endfunction
	task automatic expect_val(int kind, logic [63:0] val);
		expQ.push_back('{kind, val});
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic drain(string name);
		while (expQ.size() > 0) @(posedge clk);
		$display("test %s done", name);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Outputs are compared on the falling edge, well away from the edge that updates them.
	always @(negedge clk) begin
		if (expQ.size() > 0) begin
			cur = expQ.pop_front();
			`CHECK(observe(cur.kind), cur.val)
		end
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			finish_test();
		end
	end
	initial begin
		{chanInSelLoad, globalInSelLoad, vOutSelLoad, pinOutSelLoad} = 4'h0;
		{chanInSel, globalInSel, vOutSel, pinOutSel, chanOutFunc, chipOutFunc} = '0;
		{chanIrqSrc, chanIrqEn, chipIrqSrc, aggIrqEn, stickyClr, pinChgEn} = '0;
		modStatus = 40'hFF_FFFF_FFFF;
		void'($urandom(19));
		step(16);
		rst <= 1'b0;
		modStatus <= 40'({$urandom(), $urandom()});
		step(3);
		expect_val(0, 64'h0000_0001_0000_0000);
		expect_val(4, 64'h0000_0000_0000_000F);
		drain("reset");
		chipOutFunc <= 4'h1;
		step(3);
		expect_val(0, 64'h0);
		expect_val(2, 64'(modStatus[33:32]));
		drain("slave pins");
		// Fields 32 to 35 go to the global input selectors, the rest to the channel ones.
		for (int i = 0; i < 36; i++) begin
			code = 6'($urandom_range(41));
			if (i < 32) begin
				chanInSel[i*6 +: 6] <= code;
			end else begin
				globalInSel[(i-32)*6 +: 6] <= code;
			end
			e[i] = (code < 6'h28) ? modStatus[code] : code[0];
		end
		e[63:36] = '0;
		{chanInSelLoad, globalInSelLoad} <= 2'h3;
		step(1);
		{chanInSelLoad, globalInSelLoad} <= 2'h0;
		step(3);
		expect_val(1, 64'(e[31:0]));
		expect_val(2, 64'(e[35:32]));
		drain("input select");
		// Two rounds walk every output code at least once, data values random.
		for (int r = 0; r < 2; r++) begin
			vs = {$urandom(), $urandom(), $urandom(), $urandom()};
			ce = {$urandom(), $urandom()};
			ch = 4'($urandom());
			e = '0;
			for (int i = 0; i < 40; i++) begin
				code = 6'((i + r * 40) % 43);
				v = code - 3;
				if (code < 6'h03) e[i] = (code == 6'h01);
				else if (code < 6'h23) e[i] = ~ce[(v / 8) * 16 + vs[v*4 +: 4]];
				else if (code < 6'h27) e[i] = 1'b0;
				else e[i] = ~ch[code - 6'h27];
				pinOutSel[i*6 +: 6] <= code;
			end
			{vOutSel, chanOutFunc, chipOutFunc} <= {vs, ce, ch};
			{vOutSelLoad, pinOutSelLoad} <= 2'h3;
			step(1);
			{vOutSelLoad, pinOutSelLoad} <= 2'h0;
			step(4);
			expect_val(0, e);
			drain("output select");
		end
		pinOutSel <= '0;
		pinOutSelLoad <= 1'b1;
		step(1);
		pinOutSelLoad <= 1'b0;
		step(6);
		stickyClr <= '1;
		step(1);
		stickyClr <= '0;
		step(2);
		expect_val(3, 64'h0);
		m = 40'({$urandom(), $urandom()});
		modStatus <= modStatus ^ m;
		step(4);
		expect_val(3, 64'(m));
		expect_val(6, 64'(modStatus));
		drain("change flags");
		c = 40'({$urandom(), $urandom()});
		stickyClr <= c;
		step(1);
		stickyClr <= '0;
		step(2);
		expect_val(3, 64'(m & ~c));
		drain("change clear");
		for (int r = 0; r < 4; r++) begin
			cs = $urandom();
			ce = {$urandom(), $urandom()};
			ae = (r == 3) ? 48'h0 : 48'({$urandom(), $urandom()});
			ch = 4'($urandom());
			for (int g = 0; g < 8; g++) e[g] = |(cs[(g/2)*8 +: 8] & ce[g*8 +: 8]);
			for (int a = 0; a < 4; a++) e[a+8] = ~((|({e[7:0], ch} & ae[a*12 +: 12])) | (r == 3 && (|(m & ~c))));
			{chanIrqSrc, chanIrqEn, aggIrqEn, chipIrqSrc} <= {cs, ce, ae, ch};
			pinChgEn <= (r == 3) ? '1 : '0;
			step(5);
			expect_val(5, 64'(e[7:0]));
			expect_val(4, 64'(e[11:8]));
			drain("interrupts");
		end
		pinOutSel <= 240'(6'h23);
		pinOutSelLoad <= 1'b1;
		step(1);
		pinOutSelLoad <= 1'b0;
		step(4);
		expect_val(0, {63'h0, ~e[8]});
		drain("interrupt pin");
		finish_test();
	end
endmodule // gma_gpio_core_bench
bind gma_gpio_core gma_gpio_props #(.CHAN_IRQ_SRCS(CHAN_IRQ_SRCS), .CHIP_IRQ_SRCS(CHIP_IRQ_SRCS))
	u_gma_gpio_props (.clk(clk), .rst(rst), .pinOut(pinOut), .pinLevel(pinLevel),
	.pinChangeSticky(pinChangeSticky), .pinChangeClear(pinChangeClear),
	.pinChangeIrqEn(pinChangeIrqEn), .pinChangeMasked(pinChangeMasked), .chanIrqSrc(chanIrqSrc),
	.chanIrqEn(chanIrqEn), .chanIrqMasked(chanIrqMasked), .chanIrq(chanIrq),
	.chipIrqSrc(chipIrqSrc), .aggIrqEn(aggIrqEn), .aggIrqMasked(aggIrqMasked), .aggIrqN(aggIrqN));
`default_nettype wire
